// file: design/rc_ctrl.sv
// Purpose: control logic for a 5-bit ratiometric reference converter
// Assumes: plain register port with one-cycle strobes; pins are asynchronous
// Notes: analog ladder is steered by registered switch controls only
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module rc_ctrl
    import rc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [RC_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic LADDER_POWER,
    output logic [RC_LEVEL_W-1:0] LADDER_LEVEL,
    output logic LADDER_TOP_VREF,
    output logic TAP_CONNECT,
    output logic TAP_FORCE_TOP,
    output logic TAP_FORCE_BOTTOM,
    output logic REF_INT_VALID,
    input wire logic [RC_PIN_COUNT-1:0] PORT_OUT,
    input wire logic [RC_PIN_COUNT-1:0] PORT_OE,
    output logic [RC_PIN_COUNT-1:0] PORT_RD,
    input wire logic [RC_PIN_COUNT-1:0] PAD_IN,
    output logic [RC_PIN_COUNT-1:0] PAD_OUT,
    output logic [RC_PIN_COUNT-1:0] PAD_OE,
    output logic [RC_PIN_COUNT-1:0] PAD_IE,
    output logic [RC_PIN_COUNT-1:0] PAD_ANALOG
);
    logic [7:0] control_reg;
    logic [7:0] level_reg;
    logic [7:0] aux_reg;
    logic [7:0] next_control_reg;
    logic [7:0] next_level_reg;
    logic [7:0] next_aux_reg;
    logic [7:0] next_rdata;
    logic conv_enable;
    logic low_power_state_select;
    logic pos_source_select;
    logic [RC_LEVEL_W-1:0] level_select;
    logic [RC_PIN_COUNT-1:0] pin_ref_sel;
    logic [RC_PIN_COUNT-1:0] pad_in_sync;
    rc_mode_type mode;
    rc_mode_type next_mode;
    logic next_tap_connect;
    logic next_tap_force_top;
    logic next_tap_force_bottom;

    assign conv_enable = control_reg[RC_ENABLE_BIT];
    assign pos_source_select = control_reg[RC_POS_SRC_BIT];
    assign low_power_state_select = aux_reg[RC_LPS_BIT];
    assign level_select = level_reg[RC_LEVEL_W-1:0];
    // index 0 is pin a, index 1 is pin b
    assign pin_ref_sel[0] = control_reg[RC_PIN_A_OE_BIT];
    assign pin_ref_sel[1] = control_reg[RC_PIN_B_OE_BIT];

    // register file: only writes and reset change it, so a sleep wake-up cannot disturb it
    always_comb begin
        next_control_reg = control_reg;
        next_level_reg = level_reg;
        next_aux_reg = aux_reg;
        if (WR) begin
            if (ADDR == RC_ADDR_CONTROL) begin
                next_control_reg = WDATA & RC_CONTROL_MASK; // RQ11
            end else if (ADDR == RC_ADDR_LEVEL) begin
                next_level_reg = WDATA & RC_LEVEL_MASK; // RQ11
            end else if (ADDR == RC_ADDR_AUX) begin
                next_aux_reg = WDATA & RC_AUX_MASK; // RQ11
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            control_reg <= RC_CONTROL_RESET; // RQ10
            level_reg <= RC_LEVEL_RESET; // RQ10
            aux_reg <= RC_AUX_RESET;
        end else begin
            control_reg <= next_control_reg; // RQ9
            level_reg <= next_level_reg; // RQ2
            aux_reg <= next_aux_reg;
        end
    end

    // read data stand for exactly one cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = 8'h00;
        if (RD) begin
            if (ADDR == RC_ADDR_CONTROL) begin
                next_rdata = control_reg;
            end else if (ADDR == RC_ADDR_LEVEL) begin
                next_rdata = level_reg;
            end else if (ADDR == RC_ADDR_AUX) begin
                next_rdata = aux_reg;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ladder steering: tap, forced end, or floating when no case applies
    always_comb begin
        next_mode = RC_MODE_FLOAT;
        if (conv_enable) begin
            next_mode = RC_MODE_TAP; // RQ3
        end else if (low_power_state_select && level_select == RC_LEVEL_FULL) begin
            next_mode = RC_MODE_TOP; // RQ4
        end else if (!low_power_state_select && level_select == RC_LEVEL_ZERO) begin
            next_mode = RC_MODE_BOTTOM; // RQ4
        end
    end

    // at most one switch control; none set leaves the node floating
    always_comb begin
        next_tap_connect = 1'b0;
        next_tap_force_top = 1'b0;
        next_tap_force_bottom = 1'b0;
        case (next_mode)
            RC_MODE_TAP: begin
                next_tap_connect = 1'b1;
            end
            RC_MODE_TOP: begin
                next_tap_force_top = 1'b1;
            end
            RC_MODE_BOTTOM: begin
                next_tap_force_bottom = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // outputs lag the register by one cycle; the ladder switches see a clean edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode <= RC_MODE_FLOAT;
            LADDER_POWER <= 1'b0;
            LADDER_LEVEL <= RC_LEVEL_ZERO;
            LADDER_TOP_VREF <= 1'b0;
            TAP_CONNECT <= 1'b0;
            TAP_FORCE_TOP <= 1'b0;
            TAP_FORCE_BOTTOM <= 1'b0;
            REF_INT_VALID <= 1'b0;
        end else begin
            mode <= next_mode;
            LADDER_POWER <= conv_enable; // RQ1 RQ14
            LADDER_LEVEL <= level_select; // RQ2 RQ14
            LADDER_TOP_VREF <= pos_source_select; // RQ5
            TAP_CONNECT <= next_tap_connect; // RQ3
            TAP_FORCE_TOP <= next_tap_force_top; // RQ4
            TAP_FORCE_BOTTOM <= next_tap_force_bottom; // RQ4
            // comparator and converter channel muxes may use the node whenever it is driven
            REF_INT_VALID <= (next_mode != RC_MODE_FLOAT); // RQ12
        end
    end

    rc_sync #(
        .WIDTH(RC_PIN_COUNT)
    ) u_pad_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(PAD_IN),
        .sync_out(pad_in_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < RC_PIN_COUNT; gi++) begin : g_pin
            rc_pin u_pin (
                .clk(CLK),
                .rst_n(RST_N),
                .ref_sel(pin_ref_sel[gi]), // RQ6
                .port_out(PORT_OUT[gi]),
                .port_oe(PORT_OE[gi]),
                .pad_in_sync(pad_in_sync[gi]),
                .pad_out(PAD_OUT[gi]),
                .pad_oe(PAD_OE[gi]),
                .pad_ie(PAD_IE[gi]),
                .port_rd(PORT_RD[gi]),
                .analog_sel(PAD_ANALOG[gi])
            );
        end
    endgenerate

    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    logic wr_control;
    logic wr_level;
    assign wr_control = WR && (ADDR == RC_ADDR_CONTROL);
    assign wr_level = WR && (ADDR == RC_ADDR_LEVEL);

    sequence s_ctrl_write_held;
        wr_control ##1 !wr_control;
    endsequence

    a_enable_follows_write: assert property ( // RQ1
        s_ctrl_write_held |=> LADDER_POWER == $past(WDATA[RC_ENABLE_BIT], 2)
    ) else $error("ladder power does not follow enable write");

    a_level_follows_write: assert property ( // RQ14
        (wr_level ##1 !wr_level) |=> LADDER_LEVEL == $past(WDATA[RC_LEVEL_W-1:0], 2)
    ) else $error("ladder level does not follow level write two cycles later");

    a_top_source_select: assert property ( // RQ5
        s_ctrl_write_held |=> LADDER_TOP_VREF == $past(WDATA[RC_POS_SRC_BIT], 2)
    ) else $error("ladder top source does not follow select bit");

    a_pin_route_write: assert property ( // RQ6
        s_ctrl_write_held |=> PAD_ANALOG == {$past(WDATA[RC_PIN_B_OE_BIT], 2), $past(WDATA[RC_PIN_A_OE_BIT], 2)}
    ) else $error("pin routing does not follow output enable bits");

    a_tap_when_enabled: assert property ( // RQ3
        TAP_CONNECT == LADDER_POWER && !(TAP_CONNECT && (TAP_FORCE_TOP || TAP_FORCE_BOTTOM))
    ) else $error("tap connection does not match converter power");

    a_force_top_cause: assert property ( // RQ4
        TAP_FORCE_TOP |-> !LADDER_POWER && LADDER_LEVEL == RC_LEVEL_FULL && $past(low_power_state_select)
    ) else $error("forced top without its cause");

    a_force_bottom_cause: assert property ( // RQ4
        TAP_FORCE_BOTTOM |-> !LADDER_POWER && LADDER_LEVEL == RC_LEVEL_ZERO && !$past(low_power_state_select)
    ) else $error("forced bottom without its cause");

    a_pin_buffers_off: assert property ( // RQ7
        (PAD_ANALOG & (PAD_OE | PAD_IE)) == '0
    ) else $error("digital buffers active on a reference pin");

    a_pin_reads_zero: assert property ( // RQ8
        (PAD_ANALOG & PORT_RD) == '0
    ) else $error("reference pin reads nonzero");

    a_control_holds: assert property ( // RQ9
        !wr_control |=> control_reg == $past(control_reg)
    ) else $error("control register changed without a write");

    a_reset_clears: assert property ( // RQ10
        disable iff (1'b0) $rose(RST_N) |-> !LADDER_POWER && LADDER_LEVEL == RC_LEVEL_ZERO && PAD_ANALOG == '0
    ) else $error("reset did not clear converter state");

    a_unimpl_read_zero: assert property ( // RQ11
        RD ##1 1'b1 |-> ($past(ADDR) == RC_ADDR_CONTROL) ? ((RDATA & ~RC_CONTROL_MASK) == 8'h00)
            : ($past(ADDR) == RC_ADDR_LEVEL) ? ((RDATA & ~RC_LEVEL_MASK) == 8'h00)
            : ($past(ADDR) == RC_ADDR_AUX) ? ((RDATA & ~RC_AUX_MASK) == 8'h00) : (RDATA == 8'h00)
    ) else $error("unimplemented bits read as one");

    a_rdata_one_cycle: assert property (
        !$past(RD) |-> RDATA == 8'h00
    ) else $error("read data present without a read");

    a_internal_valid: assert property ( // RQ12
        REF_INT_VALID == (TAP_CONNECT || TAP_FORCE_TOP || TAP_FORCE_BOTTOM)
    ) else $error("internal reference valid mismatch");

    a_mode_tap: assert property ( // RQ3
        TAP_CONNECT == (mode == RC_MODE_TAP)
    ) else $error("tap connection does not match registered mode");

    a_mode_top: assert property ( // RQ4
        TAP_FORCE_TOP == (mode == RC_MODE_TOP)
    ) else $error("forced top does not match registered mode");

    a_mode_bottom: assert property ( // RQ4
        TAP_FORCE_BOTTOM == (mode == RC_MODE_BOTTOM)
    ) else $error("forced bottom does not match registered mode");

    a_float_idle: assert property ( // RQ12
        (mode == RC_MODE_FLOAT) |-> !REF_INT_VALID
    ) else $error("internal reference valid while floating");

    a_force_exclusive: assert property ( // RQ4
        !(TAP_FORCE_TOP && TAP_FORCE_BOTTOM)
    ) else $error("both ladder ends forced at once");

    a_level_read_back: assert property ( // RQ2
        RD && ADDR == RC_ADDR_LEVEL |=> RDATA == $past(level_reg)
    ) else $error("level register read back wrong");

    // the edge that leaves reset still sees the pad registers at their reset values, so it is skipped
    a_pin_follows_port: assert property ( // RQ7
        $past(RST_N) |-> PAD_OE == ($past(PORT_OE) & ~$past(pin_ref_sel))
    ) else $error("pad driver enable does not follow the port");

    a_write_unmapped: assert property ( // RQ11
        WR && ADDR != RC_ADDR_CONTROL && ADDR != RC_ADDR_LEVEL && ADDR != RC_ADDR_AUX |=>
            control_reg == $past(control_reg) && level_reg == $past(level_reg) && aux_reg == $past(aux_reg)
    ) else $error("write to an unmapped index changed a register");

    c_enabled_tap: cover property (wr_control ##2 TAP_CONNECT);
    c_forced_top: cover property (TAP_FORCE_TOP);
    c_forced_bottom: cover property (wr_level ##2 TAP_FORCE_BOTTOM);
    c_both_pins: cover property (PAD_ANALOG == 2'h3);
    c_level_read: cover property (RD && ADDR == RC_ADDR_LEVEL ##1 RDATA != 8'h00);
endmodule : rc_ctrl
`default_nettype wire

// file: design/rc_pin.sv
// Purpose: per-pin override of the digital buffers while the reference is routed out
// Assumes: pad_in_sync already passed the synchroniser
// Notes: all outputs registered, so they move one cycle after the select
`timescale 1ns/100ps
`default_nettype none
module rc_pin
    import rc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_sel,
    input wire logic port_out,
    input wire logic port_oe,
    input wire logic pad_in_sync,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_ie,
    output logic port_rd,
    output logic analog_sel
);
    logic next_pad_out;
    logic next_pad_oe;
    logic next_pad_ie;
    logic next_port_rd;

    always_comb begin
        next_pad_out = port_out;
        next_pad_oe = port_oe;
        next_pad_ie = 1'b1;
        next_port_rd = pad_in_sync;
        if (ref_sel) begin
            // driver and threshold detector off so the analog level is not loaded
            next_pad_out = 1'b0; // RQ7
            next_pad_oe = 1'b0; // RQ7
            next_pad_ie = 1'b0; // RQ7
            next_port_rd = 1'b0; // RQ8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            pad_ie <= 1'b1;
            port_rd <= 1'b0;
            analog_sel <= 1'b0;
        end else begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            pad_ie <= next_pad_ie;
            port_rd <= next_port_rd;
            analog_sel <= ref_sel; // RQ6
        end
    end
endmodule : rc_pin
`default_nettype wire

// file: design/rc_pkg.sv
// Purpose: constants and types for the ratiometric reference converter control block
// Assumes: 8-bit register port, one clock at 100 MHz
// Notes: register indices are byte offsets on the plain register port
//
// Overview of operation
// [RQ1] converter powers up only while enable bit 7 of control register is set
// [RQ2] five-bit level field in bits 4..0 of level register picks one of 32 levels
// [RQ3] enabled output is bottom source plus span times level over 2^5, bottom is ground
// [RQ4] disabled: low-power select 1 and level 11111 gives top; 0 and 00000 gives bottom
// [RQ5] positive source select bit 2 ties ladder top to reference pin, else supply
// [RQ6] bit 5 routes output to pin a, bit 4 to pin b; clear disconnects
// [RQ7] a pin carrying the reference loses its digital driver and input detector
// [RQ8] digital read of a pin carrying the reference always returns 0
// [RQ9] waking from sleep leaves every control register bit unchanged
// [RQ10] any reset disables converter, removes pin outputs, clears level field
// [RQ11] unimplemented bits ignore writes and read as zero
// [RQ12] converter output offered to comparator positive input and converter channel
// [RQ13] software should disable the reference before sleep to save current
// [RQ14] writes land on the clock edge; ladder outputs follow one cycle later
package rc_pkg;
    localparam int RC_ADDR_W = 2;
    localparam logic [RC_ADDR_W-1:0] RC_ADDR_CONTROL = 2'h0;
    localparam logic [RC_ADDR_W-1:0] RC_ADDR_LEVEL = 2'h1;
    localparam logic [RC_ADDR_W-1:0] RC_ADDR_AUX = 2'h2;
    localparam int RC_ENABLE_BIT = 7;
    localparam int RC_PIN_A_OE_BIT = 5;
    localparam int RC_PIN_B_OE_BIT = 4;
    localparam int RC_POS_SRC_BIT = 2;
    localparam int RC_LPS_BIT = 0;
    localparam int RC_LEVEL_W = 5;
    localparam int RC_PIN_COUNT = 2;
    localparam logic [7:0] RC_CONTROL_MASK = 8'hB4;
    localparam logic [7:0] RC_LEVEL_MASK = 8'h1F;
    localparam logic [7:0] RC_AUX_MASK = 8'h01;
    localparam logic [7:0] RC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] RC_LEVEL_RESET = 8'h00;
    localparam logic [7:0] RC_AUX_RESET = 8'h00;
    localparam logic [RC_LEVEL_W-1:0] RC_LEVEL_FULL = 5'h1F;
    localparam logic [RC_LEVEL_W-1:0] RC_LEVEL_ZERO = 5'h00;

    typedef enum logic [1:0] {
        RC_MODE_FLOAT,
        RC_MODE_TAP,
        RC_MODE_TOP,
        RC_MODE_BOTTOM
    } rc_mode_type;
endpackage : rc_pkg

// file: design/rc_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module rc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : rc_sync
`default_nettype wire

// file: sim/rc_ctrl_tb.sv
// Purpose: self-checking bench for the reference converter control block
// Assumes: register reads answer exactly one cycle after the strobe
// Notes: read results are compared by a monitor against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module rc_ctrl_tb
    import rc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [RC_ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic power, top_vref, connect, f_top, f_bot, int_valid, vout_valid;
    logic [RC_LEVEL_W-1:0] level;
    logic [1:0] port_out = 2'h0;
    logic [1:0] port_oe = 2'h0;
    logic [1:0] port_rd, pad_in, pad_out, pad_oe, pad_ie, pad_analog, a;
    logic [5:0] vout;
    logic [7:0] exp_q[$];
    logic [7:0] r, c;
    logic [7:0] ctl [6] = '{8'h00, 8'h04, 8'h20, 8'h10, 8'h30, 8'h34};
    logic rd_seen = 1'b0;
    int miscompares = 0;
    int n_checks = 0;
    int seed = 30189;

    rc_ctrl uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .LADDER_POWER(power), .LADDER_LEVEL(level), .LADDER_TOP_VREF(top_vref), .TAP_CONNECT(connect),
        .TAP_FORCE_TOP(f_top), .TAP_FORCE_BOTTOM(f_bot), .REF_INT_VALID(int_valid), .PORT_OUT(port_out),
        .PORT_OE(port_oe), .PORT_RD(port_rd), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
        .PAD_IE(pad_ie), .PAD_ANALOG(pad_analog));
    rc_far_model far (.clk(clk), .power(power), .level(level), .connect(connect), .force_top(f_top),
        .force_bottom(f_bot), .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog(pad_analog), .pad_in(pad_in),
        .vout(vout), .vout_valid(vout_valid));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic rr, input logic [RC_ADDR_W-1:0] ad, input logic [7:0] d,
        input logic [7:0] e);
        // requests always start just after a rising edge
        if (!clk) @(posedge clk);
        wr <= w;
        rd <= rr;
        addr <= ad;
        wdata <= d;
        if (rr) exp_q.push_back(e);
        @(posedge clk);
    endtask : bus
    task automatic idle(input int n);
        if (!clk) @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    // write, then wait until the ladder outputs have followed
    task automatic put(input logic [RC_ADDR_W-1:0] ad, input logic [7:0] d);
        bus(1'b1, 1'b0, ad, d, 8'h00);
        idle(1);
        @(negedge clk);
    endtask : put
    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        if (rd_seen) chk(rdata, exp_q.pop_front());
        rd_seen <= rd;
    end
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        idle(2);
        @(negedge clk);
        chk({pad_ie, pad_analog, pad_oe, f_bot, power}, 8'hC2);
        for (int i = 0; i < 4; i++) bus(1'b0, 1'b1, i[1:0], 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) bus(1'b1, 1'b0, i[1:0], 8'hFF, 8'h00);
        bus(1'b0, 1'b1, RC_ADDR_CONTROL, 8'h00, RC_CONTROL_MASK);
        bus(1'b0, 1'b1, RC_ADDR_LEVEL, 8'h00, RC_LEVEL_MASK);
        bus(1'b0, 1'b1, RC_ADDR_AUX, 8'h00, RC_AUX_MASK);
        bus(1'b0, 1'b1, 2'h3, 8'h00, 8'h00);
        idle(2);
        $display("test registers done");
        for (int i = 0; i < 32; i++) begin
            r = 8'($random(seed));
            put(RC_ADDR_LEVEL, {r[7:5], i[4:0]});
            chk(level, i[7:0]);
            chk(vout, i[7:0]);
            chk({connect, power, f_top, f_bot, int_valid}, 8'h19);
        end
        bus(1'b1, 1'b0, RC_ADDR_CONTROL, 8'h00, 8'h00);
        idle(0);
        @(negedge clk);
        chk(power, 8'h01);
        @(negedge clk);
        chk({power, connect}, 8'h00);
        $display("test enabled levels done");
        for (int j = 0; j < 4; j++) begin
            bus(1'b1, 1'b0, RC_ADDR_AUX, {7'h00, j[0]}, 8'h00);
            put(RC_ADDR_LEVEL, j[1] ? 8'h1F : 8'h00);
            chk({f_top, f_bot, int_valid, connect}, (j == 3) ? 8'hA : (j == 0) ? 8'h6 : 8'h0);
            chk({vout_valid, vout}, (j == 3) ? 8'h60 : (j == 0) ? 8'h40 : 8'h00);
        end
        $display("test disabled modes done");
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            r = 8'($random(seed));
            port_out <= r[1:0];
            port_oe <= r[3:2];
            c = ctl[k % 6];
            put(RC_ADDR_CONTROL, c);
            idle(3);
            @(negedge clk);
            a = {c[4], c[5]};
            chk({top_vref, pad_analog}, {5'h00, c[2], a});
            chk({pad_oe, pad_ie, pad_out}, {2'h0, r[3:2] & ~a, ~a, r[1:0] & ~a});
            chk(port_rd & (r[3:2] | a), r[1:0] & r[3:2] & ~a);
        end
        $display("test pins done");
        put(RC_ADDR_LEVEL, 8'h15);
        // converter left powered down across the long quiet spell
        idle(50);
        bus(1'b0, 1'b1, RC_ADDR_CONTROL, 8'h00, c);
        bus(1'b0, 1'b1, RC_ADDR_LEVEL, 8'h00, 8'h15);
        idle(2);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(1);
        for (int i = 0; i < 3; i++) bus(1'b0, 1'b1, i[1:0], 8'h00, 8'h00);
        idle(3);
        @(negedge clk);
        chk({pad_analog, level}, 8'h00);
        $display("test hold and reset done");
        finish_test();
    end
endmodule : rc_ctrl_tb
`default_nettype wire

// file: sim/rc_far_model.sv
// Purpose: far-side model of the resistor ladder and the two reference pins
// Assumes: pins have no pull, so an undriven or analog pin wanders
// Notes: vout is in 32nds of the span, 32 means the top source itself
`timescale 1ns/100ps
`default_nettype none
module rc_far_model (
    input wire logic clk,
    input wire logic power,
    input wire logic [4:0] level,
    input wire logic connect,
    input wire logic force_top,
    input wire logic force_bottom,
    input wire logic [1:0] pad_out,
    input wire logic [1:0] pad_oe,
    input wire logic [1:0] pad_analog,
    output logic [1:0] pad_in,
    output logic [5:0] vout,
    output logic vout_valid
);
    logic wander = 1'b0;
    always @(posedge clk) begin
        wander <= ~wander;
    end
    // a released pin toggles so that a stale level can never pass as a read
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pad_in[i] = (pad_oe[i] && !pad_analog[i]) ? pad_out[i] : wander;
        end
    end
    always_comb begin
        vout_valid = connect || force_top || force_bottom;
        vout = 6'h00;
        if (connect && power) begin
            vout = {1'b0, level};
        end else if (force_top) begin
            vout = 6'h20;
        end
    end
endmodule : rc_far_model
`default_nettype wire
